// ===== hw/sbrg_consts.svh
// Offsets, field positions, reset values and counts of the serial rate generator
`ifndef SBRG_CONSTS_SVH
`define SBRG_CONSTS_SVH

`define SBRG_OFF_TXSC 8'h00
`define SBRG_OFF_RCSC 8'h04
`define SBRG_OFF_DIV 8'h08
`define SBRG_OFF_STAT 8'h0C

`define SBRG_TXSC_RST 8'h02
`define SBRG_RCSC_RST 8'h00
`define SBRG_DIV_RST 8'h00
`define SBRG_TXSC_WMASK 8'hF5
`define SBRG_RCSC_WMASK 8'hF8

`define SBRG_BIT_CLK_SRC 7
`define SBRG_BIT_SYNC 4
`define SBRG_BIT_HIGH_SPD 2
`define SBRG_BIT_SHIFT_EMPTY 1
`define SBRG_BIT_PORT_EN 7
`define SBRG_BIT_FRAME_ERR 2
`define SBRG_BIT_OVERRUN 1
`define SBRG_BIT_NINTH 0

`define SBRG_PRE_LAST_SYNC 6'h03
`define SBRG_PRE_LAST_HIGH 6'h0F
`define SBRG_PRE_LAST_LOW 6'h3F
`define SBRG_DIV_SYNC 15'h0004
`define SBRG_DIV_HIGH 15'h0010
`define SBRG_DIV_LOW 15'h0040

`endif

// ===== hw/sbrg_pkg.sv
// Types of the serial rate generator
package sbrg_pkg;
  typedef enum logic [1:0] {
    SBRG_BUS_IDLE = 2'b00,
    SBRG_BUS_RD = 2'b01,
    SBRG_BUS_WR = 2'b10
  } sbrg_bus_st_t;

  typedef enum logic [1:0] {
    SBRG_DIV4 = 2'b00,
    SBRG_DIV16 = 2'b01,
    SBRG_DIV64 = 2'b10,
    SBRG_STOP = 2'b11
  } sbrg_mode_t;
endpackage

// ===== hw/sbrg_majority.sv
// Three-sample majority detector for the receive pin
module sbrg_majority (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sample_stb,
  input wire logic rx_in,
  output logic level
);
  logic [2:0] samp_ff;
  logic level_ff;
  logic [2:0] nxt_samp;

  assign nxt_samp = {samp_ff[1:0], rx_in};
  assign level = level_ff;

  // Idle line is high, so start the history high
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      samp_ff <= 3'h7;
    end else if (sample_stb) begin
      samp_ff <= nxt_samp;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level_ff <= 1'b1;
    end else if (sample_stb) begin
      level_ff <= (nxt_samp[0] & nxt_samp[1]) | (nxt_samp[0] & nxt_samp[2]) |
                  (nxt_samp[1] & nxt_samp[2]);
    end
  end

  majority_vote_a: assert property (@(posedge sys_clk) disable iff (rst)
    sample_stb |=> level_ff == ((samp_ff[0] & samp_ff[1]) | (samp_ff[0] & samp_ff[2]) |
                                (samp_ff[1] & samp_ff[2])))
    else $error("majority level does not follow the three samples");

  hold_level_a: assert property (@(posedge sys_clk) disable iff (rst)
    !sample_stb |=> $stable(level_ff))
    else $error("level changed without a sample strobe");
endmodule

// ===== hw/sbrg_top.sv
// Serial rate generator with AHB-Lite register slave and receive majority sampler
//
// Implementation choices: the register offsets and register access over AHB-Lite.
`include "sbrg_consts.svh"

// Overview of operation
// - One dedicated 8-bit free-running timer, period set by the divisor, serves both modes.
// - The divisor X is an unsigned 0 to 255 taken straight from the divisor register.
// - Asynchronous with high speed clear gives one tick per 64 times (X+1) clocks.
// - Asynchronous with high speed set gives one tick per 16 times (X+1) clocks.
// - The high speed bit, bit 2 of transmit control, matters only in asynchronous mode.
// - Synchronous mode ignores high speed and gives one tick per 4 times (X+1) clocks.
// - Synchronous rates apply only in master role; as synchronous slave the generator does not run, while asynchronous mode runs in either role.
// - Any write to the divisor clears the timer at once so the new rate starts now.
// - The receive pin is sampled three times and resolved by majority vote.
module sbrg_top (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic receive_data_pin,
  input wire logic shift_register_empty,
  input wire logic framing_error_flag,
  input wire logic overrun_error_flag,
  input wire logic receive_ninth_bit,
  output logic rate_tick,
  output logic rx_level,
  output logic [7:0] transmit_status_control,
  output logic [7:0] receive_status_control
);
  sbrg_pkg::sbrg_bus_st_t bus_st_ff;
  logic [7:0] addr_ff;
  logic [31:0] hrdata_ff;
  logic hreadyout_ff;
  logic hresp_ff;
  logic [7:0] txsc_ff;
  logic [7:0] rcsc_ff;
  logic [7:0] div_ff;
  logic [5:0] pre_ff;
  logic [7:0] timer_ff;
  logic rate_tick_ff;
  logic addr_take;
  logic wr_now;
  logic div_wr;
  logic run;
  logic pre_wrap;
  logic [5:0] pre_last;
  logic [31:0] nxt_rdata;
  sbrg_pkg::sbrg_mode_t mode;

  // hsize is not decoded: only whole-word transfers reach this slave
  assign addr_take = hsel & htrans[1] & hready;
  assign wr_now = (bus_st_ff == sbrg_pkg::SBRG_BUS_WR);
  assign div_wr = wr_now & (addr_ff == `SBRG_OFF_DIV);

  assign hrdata = hrdata_ff;
  assign hreadyout = hreadyout_ff;
  assign hresp = hresp_ff;
  assign rate_tick = rate_tick_ff;
  assign transmit_status_control = txsc_ff;
  assign receive_status_control = rcsc_ff;

  // Bus phase tracking
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_st_ff <= sbrg_pkg::SBRG_BUS_IDLE;
      addr_ff <= 8'h00;
    end else if (bus_st_ff == sbrg_pkg::SBRG_BUS_RD) begin
      bus_st_ff <= sbrg_pkg::SBRG_BUS_IDLE;
    end else if (addr_take) begin
      bus_st_ff <= hwrite ? sbrg_pkg::SBRG_BUS_WR : sbrg_pkg::SBRG_BUS_RD;
      addr_ff <= haddr[7:0];
    end else begin
      bus_st_ff <= sbrg_pkg::SBRG_BUS_IDLE;
    end
  end

  // One wait state on reads so a read right after a write sees the new value
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hreadyout_ff <= 1'b1;
    end else if (bus_st_ff == sbrg_pkg::SBRG_BUS_RD) begin
      hreadyout_ff <= 1'b1;
    end else if (addr_take & !hwrite) begin
      hreadyout_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hresp_ff <= 1'b0;
    end else begin
      hresp_ff <= 1'b0;
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (addr_ff)
      `SBRG_OFF_TXSC: nxt_rdata = {24'h00_0000, txsc_ff};
      `SBRG_OFF_RCSC: nxt_rdata = {24'h00_0000, rcsc_ff};
      `SBRG_OFF_DIV: nxt_rdata = {24'h00_0000, div_ff};
      `SBRG_OFF_STAT: nxt_rdata = {30'h0000_0000, run, rx_level};
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (bus_st_ff == sbrg_pkg::SBRG_BUS_RD) begin
      hrdata_ff <= nxt_rdata;
    end
  end

  // Status word: software polls it to see whether the generator is live
  status_read_a: assert property (@(posedge sys_clk) disable iff (rst)
    (bus_st_ff == sbrg_pkg::SBRG_BUS_RD && addr_ff == `SBRG_OFF_STAT) |=>
      hrdata_ff == {30'h0000_0000, $past(run), $past(rx_level)})
    else $error("status word does not show run state and receive level");

  // Transmit control: status bit tracks the transmitter, bit 3 reads zero
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      txsc_ff <= `SBRG_TXSC_RST;
    end else begin
      if (wr_now && addr_ff == `SBRG_OFF_TXSC) begin
        txsc_ff <= (hwdata[7:0] & `SBRG_TXSC_WMASK) | (txsc_ff & ~`SBRG_TXSC_WMASK);
      end
      txsc_ff[3] <= 1'b0;
      txsc_ff[`SBRG_BIT_SHIFT_EMPTY] <= shift_register_empty;
    end
  end

  speed_bit_a: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_now && addr_ff == `SBRG_OFF_TXSC) |=>
      txsc_ff[`SBRG_BIT_HIGH_SPD] == $past(hwdata[`SBRG_BIT_HIGH_SPD]))
    else $error("high speed bit did not take the written value");

  // Receive control: error and ninth bits come from the receiver
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rcsc_ff <= `SBRG_RCSC_RST;
    end else begin
      if (wr_now && addr_ff == `SBRG_OFF_RCSC) begin
        rcsc_ff <= (hwdata[7:0] & `SBRG_RCSC_WMASK) | (rcsc_ff & ~`SBRG_RCSC_WMASK);
      end
      rcsc_ff[`SBRG_BIT_FRAME_ERR] <= framing_error_flag;
      rcsc_ff[`SBRG_BIT_OVERRUN] <= overrun_error_flag;
      rcsc_ff[`SBRG_BIT_NINTH] <= receive_ninth_bit;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_ff <= `SBRG_DIV_RST;
    end else if (div_wr) begin
      div_ff <= hwdata[7:0];
    end
  end

  div_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !div_wr |=> $stable(div_ff))
    else $error("divisor changed without a write");

  // Synchronous mode runs in master role only: synchronous slave takes its clock from the pin
  assign run = rcsc_ff[`SBRG_BIT_PORT_EN] &
               (!txsc_ff[`SBRG_BIT_SYNC] | txsc_ff[`SBRG_BIT_CLK_SRC]);

  always_comb begin
    if (!run) begin
      mode = sbrg_pkg::SBRG_STOP;
    end else if (txsc_ff[`SBRG_BIT_SYNC]) begin
      mode = sbrg_pkg::SBRG_DIV4;
    end else if (txsc_ff[`SBRG_BIT_HIGH_SPD]) begin
      mode = sbrg_pkg::SBRG_DIV16;
    end else begin
      mode = sbrg_pkg::SBRG_DIV64;
    end
  end

  always_comb begin
    case (mode)
      sbrg_pkg::SBRG_DIV4: pre_last = `SBRG_PRE_LAST_SYNC;
      sbrg_pkg::SBRG_DIV16: pre_last = `SBRG_PRE_LAST_HIGH;
      sbrg_pkg::SBRG_DIV64: pre_last = `SBRG_PRE_LAST_LOW;
      default: pre_last = `SBRG_PRE_LAST_LOW;
    endcase
  end

  assign pre_wrap = run & (pre_ff == pre_last);

  // Prescaler gives the timer its input period; a mode change can overshoot, so wrap on >=
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      pre_ff <= 6'h00;
    end else if (div_wr || !run || pre_ff >= pre_last) begin
      pre_ff <= 6'h00;
    end else begin
      pre_ff <= pre_ff + 6'h01;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      timer_ff <= 8'h00;
    end else if (div_wr || !run) begin
      timer_ff <= 8'h00;
    end else if (pre_wrap) begin
      if (timer_ff >= div_ff) begin
        timer_ff <= 8'h00;
      end else begin
        timer_ff <= timer_ff + 8'h01;
      end
    end
  end

  // A divisor write clears the timer on the same edge, so it never passes the divisor
  timer_cap_a: assert property (@(posedge sys_clk) disable iff (rst)
    div_ff >= timer_ff)
    else $error("timer ran past the divisor");

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rate_tick_ff <= 1'b0;
    end else begin
      rate_tick_ff <= !div_wr & pre_wrap & (timer_ff >= div_ff);
    end
  end

  // Shortest period is four clocks, so two ticks in a row mean a broken reload
  tick_width_a: assert property (@(posedge sys_clk) disable iff (rst)
    rate_tick_ff |=> !rate_tick_ff)
    else $error("rate tick stood longer than one cycle");

  sbrg_majority u_majority (
    .sys_clk(sys_clk),
    .rst(rst),
    .sample_stb(pre_wrap),
    .rx_in(receive_data_pin),
    .level(rx_level)
  );

  // No strobes while stopped, so the voted level must freeze
  stop_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    !run |=> $stable(rx_level))
    else $error("receive level moved while the generator was stopped");

  // Helper logic for the period checks
  logic [14:0] since_ff;
  logic seen_ff;
  logic [2:0] prev_key_ff;
  logic [14:0] exp_last;
  logic [14:0] div_fac;

  always_comb begin
    case (mode)
      sbrg_pkg::SBRG_DIV4: div_fac = `SBRG_DIV_SYNC;
      sbrg_pkg::SBRG_DIV16: div_fac = `SBRG_DIV_HIGH;
      default: div_fac = `SBRG_DIV_LOW;
    endcase
  end

  assign exp_last = 15'(({7'h00, div_ff} + 15'h0001) * div_fac) - 15'h0001;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      since_ff <= 15'h0000;
      seen_ff <= 1'b0;
      prev_key_ff <= 3'h0;
    end else begin
      prev_key_ff <= {run, txsc_ff[`SBRG_BIT_SYNC], txsc_ff[`SBRG_BIT_HIGH_SPD]};
      if (rate_tick_ff) begin
        since_ff <= 15'h0000;
        seen_ff <= 1'b1;
      end else begin
        since_ff <= since_ff + 15'h0001;
      end
      if (div_wr || prev_key_ff != {run, txsc_ff[`SBRG_BIT_SYNC],
                                    txsc_ff[`SBRG_BIT_HIGH_SPD]}) begin
        seen_ff <= 1'b0;
      end
    end
  end

  sequence clean_period_s;
    seen_ff && !div_wr && prev_key_ff == {run, txsc_ff[`SBRG_BIT_SYNC],
                                          txsc_ff[`SBRG_BIT_HIGH_SPD]};
  endsequence

  async_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rate_tick_ff && mode == sbrg_pkg::SBRG_DIV64) ##0 clean_period_s |->
      since_ff == exp_last)
    else $error("low speed asynchronous period is not 64 times X+1");

  async_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rate_tick_ff && mode == sbrg_pkg::SBRG_DIV16) ##0 clean_period_s |->
      since_ff == exp_last)
    else $error("high speed asynchronous period is not 16 times X+1");

  sync_rate_a: assert property (@(posedge sys_clk) disable iff (rst)
    (rate_tick_ff && mode == sbrg_pkg::SBRG_DIV4) ##0 clean_period_s |->
      since_ff == exp_last)
    else $error("synchronous period is not 4 times X+1");

  sync_ignore_a: assert property (@(posedge sys_clk) disable iff (rst)
    (run && txsc_ff[`SBRG_BIT_SYNC]) |-> pre_last == `SBRG_PRE_LAST_SYNC)
    else $error("high speed bit altered the synchronous prescale");

  slave_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
    !run [*2] |-> !rate_tick_ff && timer_ff == 8'h00)
    else $error("generator ran while in slave role or disabled");

  div_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
    div_wr |=> timer_ff == 8'h00 && pre_ff == 6'h00 && !rate_tick_ff &&
               div_ff == $past(hwdata[7:0]))
    else $error("divisor write did not restart the timer");

  timer_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 $changed(timer_ff) && !$past(div_wr) |->
      timer_ff == 8'h00 || timer_ff == $past(timer_ff) + 8'h01)
    else $error("timer moved other than by one or reload");

  reload_tick_a: assert property (@(posedge sys_clk) disable iff (rst)
    (pre_wrap && timer_ff == div_ff && !div_wr) |=> rate_tick_ff && timer_ff == 8'h00)
    else $error("timer end did not reload and tick");

  sequence read_addr_s;
    addr_take && !hwrite;
  endsequence

  read_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
    read_addr_s |=> !hreadyout_ff ##1 hreadyout_ff)
    else $error("read did not take exactly one wait state");
endmodule

// ===== testbench/sbrg_remote_station.sv
// Remote serial station driving the receive line, with a commanded one-sample glitch
module sbrg_remote_station #(
  parameter int GLITCH_CYC = 4
) (
  input wire logic sys_clk,
  input wire logic line_level,
  input wire logic glitch_req,
  output logic rx_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt = 0;
  // Glitch spans one prescaler wrap in sync X=0, so exactly one sample is hit
  always @(posedge sys_clk) begin
    if (glitch_req) begin
      cnt <= GLITCH_CYC;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign rx_pin = (cnt != 0) ? ~line_level : line_level;
endmodule

// ===== testbench/tb_top.sv
// Self-checking bench for the serial rate generator
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] txsc; logic [7:0] div; int per;} sbrg_row_t;
  logic sys_clk = 0, rst = 1, hsel = 0, hwrite = 0, line_level = 1, glitch_req = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, pin, sre = 1, fe = 0, oe = 0, n9 = 0, rate_tick, rx_level;
  logic [7:0] txsc_q, rcsc_q;
  int err_total = 0, samples_checked = 0, gap, n;
  sbrg_row_t rows[7] = '{'{8'h00, 8'h00, 64}, '{8'h00, 8'h02, 192}, '{8'h04, 8'h02, 48},
    '{8'h84, 8'h01, 32}, '{8'h90, 8'h05, 24}, '{8'h94, 8'h00, 4}, '{8'h94, 8'hFF, 1024}};

  always #4 sys_clk = ~sys_clk;

  sbrg_top DUT (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .receive_data_pin(pin), .shift_register_empty(sre),
    .framing_error_flag(fe), .overrun_error_flag(oe), .receive_ninth_bit(n9),
    .rate_tick(rate_tick), .rx_level(rx_level), .transmit_status_control(txsc_q),
    .receive_status_control(rcsc_q));

  sbrg_remote_station peer (.sys_clk(sys_clk), .line_level(line_level),
    .glitch_req(glitch_req), .rx_pin(pin));

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Single word transfer; waits on hready, no fixed latency assumed
  task automatic xfer(logic wr, logic [7:0] a, logic [31:0] d);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
    check("hresp", 32'(hresp), 32'h0);
  endtask

  task automatic cfg(logic [7:0] t, logic [7:0] r, logic [7:0] d);
    xfer(1'b1, 8'h00, {24'h000000, t});
    xfer(1'b1, 8'h04, {24'h000000, r});
    xfer(1'b1, 8'h08, {24'h000000, d});
  endtask

  // Period from one tick to the next, sampled mid-cycle
  task automatic tick_gap(int lim);
    n = 0;
    @(negedge sys_clk);
    while (rate_tick !== 1'b1 && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    gap = 0;
    do begin
      @(negedge sys_clk);
      gap++;
    end while (rate_tick !== 1'b1 && gap < lim);
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #160000;
    err_total++;
    summarize();
  end

  initial begin
    repeat (16) @(posedge sys_clk);
    check("reset outputs", 32'({rate_tick, rx_level, hreadyout, hresp, txsc_q, rcsc_q}),
      32'({1'b0, 1'b1, 1'b1, 1'b0, 8'h02, 8'h00}));
    rst <= 1'b0;
    xfer(1'b0, 8'h00, 32'h0);
    check("txsc reset", rd, 32'h00000002);
    xfer(1'b0, 8'h04, 32'h0);
    check("rcsc reset", rd, 32'h00000000);
    xfer(1'b0, 8'h08, 32'h0);
    check("divisor reset", rd, 32'h00000000);
    fe <= 1'b1;
    sre <= 1'b0;
    n9 <= 1'b1;
    // Read-only bits must ignore an all-ones write
    xfer(1'b1, 8'h00, 32'hFFFFFFFF);
    xfer(1'b0, 8'h00, 32'h0);
    check("txsc write", rd, 32'h000000F5);
    check("txsc port", 32'(txsc_q), 32'h000000F5);
    xfer(1'b1, 8'h04, 32'hFFFFFFFF);
    xfer(1'b0, 8'h04, 32'h0);
    check("rcsc write", rd, 32'h000000FD);
    check("rcsc port", 32'(rcsc_q), 32'h000000FD);
    xfer(1'b1, 8'h10, 32'hFFFFFFFF);
    xfer(1'b0, 8'h10, 32'h0);
    check("unmapped", rd, 32'h00000000);
    foreach (rows[i]) begin
      cfg(rows[i].txsc, 8'h80, rows[i].div);
      xfer(1'b0, 8'h08, 32'h0);
      check("divisor", rd, {24'h000000, rows[i].div});
      tick_gap(2100);
      check("period", 32'(gap), 32'(rows[i].per));
    end
    // Restart: old period 256, new 64, written mid-period
    cfg(8'h00, 8'h80, 8'h03);
    tick_gap(600);
    check("old period", 32'(gap), 32'h100);
    repeat (100) @(posedge sys_clk);
    xfer(1'b1, 8'h08, 32'h0);
    n = 0;
    while (rate_tick !== 1'b1 && n < 300) begin
      @(negedge sys_clk);
      n++;
    end
    check("restart", 32'(n >= 64 && n <= 66), 32'h1);
    cfg(8'h90, 8'h80, 8'h00);
    for (int v = 0; v < 2; v++) begin
      line_level <= v[0];
      repeat (40) @(posedge sys_clk);
      glitch_req <= 1'b1;
      @(posedge sys_clk);
      glitch_req <= 1'b0;
      n = 0;
      repeat (40) begin
        @(negedge sys_clk);
        if (rx_level !== v[0]) n++;
      end
      check("majority", 32'(n), 32'h0);
    end
    xfer(1'b0, 8'h0C, 32'h0);
    check("status running", rd, 32'h00000003);
    // Slave role, then port disabled: no ticks at all
    for (int k = 0; k < 2; k++) begin
      cfg(k == 0 ? 8'h10 : 8'h00, k == 0 ? 8'h80 : 8'h00, 8'h00);
      n = 0;
      repeat (300) begin
        @(negedge sys_clk);
        if (rate_tick !== 1'b0) n++;
      end
      check("stopped ticks", 32'(n), 32'h0);
      xfer(1'b0, 8'h0C, 32'h0);
      check("status stopped", rd, 32'h00000001);
    end
    // Reset in mid-run with the generator live
    cfg(8'h94, 8'h80, 8'h05);
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    check("reset again", 32'({rate_tick, rx_level, hreadyout, txsc_q, rcsc_q}),
      32'({1'b0, 1'b1, 1'b1, 8'h02, 8'h00}));
    rst <= 1'b0;
    xfer(1'b0, 8'h08, 32'h0);
    check("divisor after reset", rd, 32'h00000000);
    summarize();
  end
endmodule
